/* dv/phs_host_model.sv */
// host model of the two-wire serial master facing the status block
`timescale 1ns/1ps
module phs_host_model
  import phs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic drv_lo;
  logic rx;
  int   naks = 0;
  // wired-and with a pull-up, so a released line reads high
  assign sda = ~(drv_lo | sda_oe);
  initial begin
    scl    = 1'b1;
    drv_lo = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  // data moves mid low phase, away from the clock edges
  task automatic clk9(input logic tx);
    drv_lo = ~tx;
    wt(4);
    scl = 1'b1;
    wt(8);
    rx  = sda;
    scl = 1'b0;
    wt(4);
  endtask : clk9
  task automatic start();
    drv_lo = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    drv_lo = 1'b1;
    wt(8);
    scl = 1'b0;
    wt(4);
  endtask : start
  task automatic stop();
    drv_lo = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    drv_lo = 1'b0;
    wt(8);
  endtask : stop
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk9(b[i]);
    clk9(1'b1);
    if (rx !== 1'b0) naks++;
  endtask : xfer
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    start();
    xfer({PHS_DEV_ADDR, 1'b0});
    xfer(p);
    xfer(d);
    stop();
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    start();
    xfer({PHS_DEV_ADDR, 1'b0});
    xfer(p);
    start();
    xfer({PHS_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      clk9(1'b1);
      d[i] = rx;
    end
    // no acknowledge ends the read
    clk9(1'b1);
    stop();
  endtask : rd_reg
  task automatic probe();
    start();
    xfer({~PHS_DEV_ADDR, 1'b0});
    stop();
  endtask : probe
endmodule : phs_host_model

/* dv/tb_top.sv */
// self-checking bench for the processor-hot status block
`timescale 1ns/1ps
module tb_top;
  import phs_pkg::*;
  localparam int LIMIT = 60000;
  int          cyc_w [4] = '{20, 40, 80, 60};
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  phs_trig_s   trig_src = '0;
  phs_assist_s assist   = '0;
  logic        alert_n;
  logic        mode;
  int          mismatches = 0;
  int          compares   = 0;
  int          cycles     = 0;
  int          n;
  int          idx;
  logic [31:0] lfsr = 32'h824A4ED9;
  logic [7:0]  m_lo = 8'h00;

  always #2 mclk = ~mclk;

  phs_host_model host_u (
    .mclk   (mclk),
    .sda_oe (sda_oe),
    .scl    (scl),
    .sda    (sda)
  );

  phs_alert_top #(
    .CYC_W0 (20),
    .CYC_W1 (40),
    .CYC_W2 (80),
    .CYC_W3 (60)
  ) dut_u (
    .mclk                  (mclk),
    .nrst                  (nrst),
    .scl_pin               (scl),
    .sda_pin               (sda),
    .sda_out               (sda_out),
    .sda_oe                (sda_oe),
    .trig_src              (trig_src),
    .assist                (assist),
    .processor_hot_alert_n (alert_n),
    .peak_assist_mode      (mode)
  );

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // reading the low byte empties its read-only source bits, so the model follows
  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] v;
    host_u.rd_reg(p, v);
    chk(16'(v), 16'(e));
    if (p == REG_LO) m_lo = m_lo & 8'h80;
  endtask : rdc

  task automatic fire(input int i);
    trig_src = phs_trig_s'(8'h01 << i);
    repeat (2) @(negedge mclk);
    trig_src = '0;
    m_lo = m_lo | (8'h01 << i);
  endtask : fire

  task automatic meas(output int cnt);
    int t;
    t   = 0;
    cnt = 0;
    while (alert_n !== 1'b0 && t < 10) begin
      @(negedge mclk);
      t++;
    end
    while (alert_n === 1'b0 && cnt < 2000) begin
      @(negedge mclk);
      cnt++;
    end
  endtask : meas

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk(alert_n, 1'b1);
    chk(mode, 1'b0);
    chk({sda_out, sda_oe}, 2'b00);
    rdc(REG_LO, 8'h00);
    rdc(REG_HI, 8'hA8);
    rdc(8'h24, 8'h00);
    $display("reset test done");
    for (int w = 0; w < 4; w++) begin
      host_u.wr_reg(REG_HI, 8'h08 | 8'(w << 4));
      idx = int'(rnd() % 8);
      fire(idx);
      meas(n);
      chk(16'(n >= cyc_w[w] && n <= cyc_w[w] + 6), 1'b1);
      rdc(REG_HI, 8'h88 | 8'(w << 4));
      rdc(REG_LO, m_lo);
      // only the top low bit is writable and it clears on zero
      host_u.wr_reg(REG_LO, 8'h7F);
      m_lo = 8'h00;
      rdc(REG_LO, m_lo);
    end
    $display("width test done");
    host_u.wr_reg(REG_HI, 8'h48);
    fire(4);
    repeat (200) @(negedge mclk);
    chk(alert_n, 1'b0);
    host_u.wr_reg(REG_HI, 8'h40);
    repeat (8) @(negedge mclk);
    chk(alert_n, 1'b1);
    rdc(REG_HI, 8'hC8);
    rdc(REG_LO, m_lo);
    host_u.wr_reg(REG_HI, 8'h7C);
    rdc(REG_HI, 8'hF8);
    host_u.wr_reg(REG_HI, 8'h28);
    // clear written with extension off must not cut a live pulse
    trig_src = phs_trig_s'(8'h04);
    host_u.wr_reg(REG_HI, 8'h20);
    chk(alert_n, 1'b0);
    trig_src = '0;
    m_lo = 8'h04;
    repeat (100) @(negedge mclk);
    chk(alert_n, 1'b1);
    rdc(REG_LO, m_lo);
    $display("extension test done");
    assist.req = 1'b1;
    repeat (3) @(negedge mclk);
    chk(mode, 1'b1);
    // a success in the middle restarts the failure run
    for (int k = 0; k < 14; k++) begin
      assist.load_fail = (k != 6);
      assist.load_ok   = (k == 6);
      @(negedge mclk);
      assist.load_fail = 1'b0;
      assist.load_ok   = 1'b0;
      repeat (int'(rnd() % 4) + 1) @(negedge mclk);
      chk(mode, 16'(k != 13));
    end
    rdc(REG_HI, 8'hAA);
    repeat (20) @(negedge mclk);
    chk(mode, 1'b0);
    host_u.wr_reg(REG_HI, 8'h28);
    repeat (4) @(negedge mclk);
    chk(mode, 1'b1);
    for (int c = 0; c < 2; c++) begin
      if (c == 1) begin
        assist.req = 1'b1;
        repeat (3) @(negedge mclk);
        chk(mode, 1'b1);
        assist.fault = 1'b1;
      end else begin
        assist.req = 1'b0;
      end
      repeat (2) @(negedge mclk);
      chk(mode, 1'b0);
      repeat (300) @(negedge mclk);
      chk(alert_n, 1'b0);
      rdc(REG_HI, 8'hA9);
      host_u.wr_reg(REG_HI, 8'hA8);
      repeat (8) @(negedge mclk);
      chk(alert_n, 1'b1);
    end
    assist = '0;
    $display("assist test done");
    host_u.probe();
    chk(16'(host_u.naks), 1'b1);
    $display("address test done");
    summarize();
  end
endmodule : tb_top

/* logic/phs_alert_top.sv */
// processor-hot alert pulse logic and its status register pair
//
// Functional notes
// - extension on holds alert low until cleared
// - extension enable resets to zero
// - minimum alert width from two-bit field
// - clear written zero releases pin, idles one
// - clear acts only while extension enabled
// - seven consecutive load failures set fail flag
// - failure exits assist, latched until flag cleared
// - host disable or fault exits, sets exit flag
// - exit flag holds alert low until cleared
// - low byte bits show triggered sources
// - pair at 22h/23h, resets to A800h
`timescale 1ns/1ps
module phs_alert_top
  import phs_pkg::*;
#(
  parameter int unsigned CYC_W0   = W0_CYC,
  parameter int unsigned CYC_W1   = W1_CYC,
  parameter int unsigned CYC_W2   = W2_CYC,
  parameter int unsigned CYC_W3   = W3_CYC,
  parameter logic [6:0]  DEV_ADDR = PHS_DEV_ADDR
)(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire phs_trig_s   trig_src,
  input  wire phs_assist_s assist,
  output logic             processor_hot_alert_n,
  output logic             peak_assist_mode
);
  typedef struct packed {
    logic [15:0]      st;
    phs_alert_e       ast;
    logic [TMR_W-1:0] tmr;
    logic [2:0]       fcnt;
    logic             mode;
    logic             alert_n;
    logic             boot;
    logic [7:0]       trig_q0;
    logic [7:0]       trig_q1;
  } phs_top_st_s;

  localparam phs_top_st_s RST_ST = '{st: STAT_RST, ast: PHS_A_IDLE, alert_n: 1'b1, default: '0};

  phs_top_st_s r;
  phs_top_st_s n;
  phs_rbus_s   rbus;
  logic [7:0]  ptr;
  logic [7:0]  rdata;
  logic [1:0]  sel;
  logic [7:0]  trig_s;
  logic        any_trig;
  logic        clr_wr;
  logic        clr_hit;
  logic        fail_set;
  logic        exit_set;

  // one-hot byte select: bit 0 low byte, bit 1 high byte
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == REG_HI, a == REG_LO};
  endfunction : reg_sel

  // count loaded is one short: the entry cycle is already low
  function automatic logic [TMR_W-1:0] wid_cyc(input logic [1:0] w);
    case (w)
      2'h0:    wid_cyc = TMR_W'(CYC_W0 - 1);
      2'h1:    wid_cyc = TMR_W'(CYC_W1 - 1);
      2'h2:    wid_cyc = TMR_W'(CYC_W2 - 1);
      default: wid_cyc = TMR_W'(CYC_W3 - 1);
    endcase
  endfunction : wid_cyc

  phs_i2c_slv #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slv (
    .mclk    (mclk),
    .nrst    (nrst),
    .scl_pin (scl_pin),
    .sda_pin (sda_pin),
    .rdata   (rdata),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .rbus    (rbus),
    .ptr     (ptr)
  );

  // unmapped pointers read as zero
  always_comb begin
    case (reg_sel(ptr))
      2'h1:    rdata = r.st[7:0];
      2'h2:    rdata = r.st[15:8];
      default: rdata = 8'h00;
    endcase
  end

  assign sel      = reg_sel(rbus.addr);
  assign trig_s   = r.trig_q1;
  assign any_trig = |trig_s;
  assign clr_wr   = rbus.wr && sel[1] && !rbus.wdata[B_CLR-8];
  assign clr_hit  = clr_wr && r.st[B_EXT];
  assign fail_set = r.mode && assist.load_fail && (r.fcnt == 3'(FAIL_LIMIT - 1));
  assign exit_set = r.mode && !fail_set && (!assist.req || assist.fault);

  always_comb begin
    logic [15:0] s;
    s = r.st;
    n = r;
    n.boot = 1'b1;
    // comparator outputs are asynchronous to mclk
    n.trig_q0 = trig_src;
    n.trig_q1 = r.trig_q0;
    // clear strobe returns to idle on its own
    if (!r.st[B_CLR]) begin
      s[B_CLR] = 1'b1;
    end
    if (rbus.wr && sel[0]) begin
      s[7:0] = (s[7:0] & ~WR_MASK[7:0]) | (rbus.wdata & WR_MASK[7:0]);
    end
    if (rbus.wr && sel[1]) begin
      s[15:8] = (s[15:8] & ~WR_MASK[15:8]) | (rbus.wdata & WR_MASK[15:8]);
    end
    // read-only source bits clear when the low byte is fetched
    if (rbus.rd && sel[0]) begin
      s[7:0] = s[7:0] & ~LO_RO_MASK;
    end
    // sets come last so an event never loses to a clear
    s[7:0] = s[7:0] | trig_s;
    s[B_FAIL] = s[B_FAIL] | fail_set;
    s[B_EXIT] = s[B_EXIT] | exit_set;
    n.st = s;

    if (!r.mode || assist.load_ok) begin
      n.fcnt = '0;
    end else if (assist.load_fail && !fail_set) begin
      n.fcnt = r.fcnt + 3'h1;
    end
    if (fail_set || exit_set) begin
      n.mode = 1'b0;
    end else if (!r.mode && assist.req && !assist.fault && !r.st[B_FAIL]) begin
      n.mode = 1'b1;
    end

    case (r.ast)
      PHS_A_IDLE: begin
        if (any_trig) begin
          n.ast = PHS_A_PULSE;
          n.tmr = wid_cyc(r.st[B_WID+:2]);
        end
      end
      PHS_A_PULSE: begin
        if (r.tmr != '0) begin
          n.tmr = r.tmr - 1'b1;
        end else if (r.st[B_EXT]) begin
          n.ast = PHS_A_HOLD;
        end else if (!any_trig) begin
          n.ast = PHS_A_IDLE;
        end
      end
      PHS_A_HOLD: begin
        // dropping the enable also lets go, once sources are quiet
        if (clr_hit || (!r.st[B_EXT] && !any_trig)) begin
          n.ast = PHS_A_IDLE;
        end
      end
      default: begin
        n.ast = PHS_A_IDLE;
      end
    endcase
    n.alert_n = !((n.ast != PHS_A_IDLE) || s[B_EXIT]);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= RST_ST;
    end else begin
      r <= n;
    end
  end

  assign processor_hot_alert_n = r.alert_n;
  assign peak_assist_mode      = r.mode;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  ext_hold_a: assert property (
    (r.ast == PHS_A_HOLD && r.st[B_EXT] && !clr_hit) |=> !r.alert_n && r.ast == PHS_A_HOLD)
    else $error("extended alert released without clear");

  ext_reset_a: assert property (
    !r.boot |-> !r.st[B_EXT] && r.st[B_CLR])
    else $error("extension enable not zero after reset");

  width_load_a: assert property (
    (r.ast == PHS_A_IDLE && any_trig) |=> r.tmr == wid_cyc($past(r.st[B_WID+:2])))
    else $error("alert timer loaded with wrong width");

  width_hold_a: assert property (
    (r.ast == PHS_A_PULSE && r.tmr != '0) |=> r.ast == PHS_A_PULSE && !r.alert_n)
    else $error("alert pulse ended before minimum width");

  clear_release_a: assert property (
    (r.ast == PHS_A_HOLD && clr_hit && !n.st[B_EXIT]) |=> r.alert_n ##1 r.st[B_CLR])
    else $error("clear did not release alert or return to idle");

  clear_gate_a: assert property (
    (clr_wr && !r.st[B_EXT] && r.ast == PHS_A_PULSE && r.tmr > TMR_W'(1))
      |=> r.ast == PHS_A_PULSE [*2])
    else $error("clear acted with extension disabled");

  fail_count_a: assert property (
    (r.mode && assist.load_fail && r.fcnt == 3'(FAIL_LIMIT - 1)) |=> r.st[B_FAIL] && !r.mode)
    else $error("seventh load failure did not set fail flag");

  fail_latch_a: assert property (
    r.st[B_FAIL] |=> !r.mode)
    else $error("assist mode entered while failure latched");

  exit_flag_a: assert property (
    (r.mode && (assist.fault || !assist.req)) |=> !r.mode && (r.st[B_EXIT] || r.st[B_FAIL]))
    else $error("assist exit not recorded");

  exit_pin_a: assert property (
    r.st[B_EXIT] |-> !r.alert_n)
    else $error("alert high while exit flag set");

  trig_latch_a: assert property (
    (trig_s != 8'h00) |=> (r.st[7:0] & $past(trig_s)) == $past(trig_s))
    else $error("triggered source not shown in status");

  rsv_bits_a: assert property (
    r.st[B_RSV_HI] && !r.st[B_RSV_LO])
    else $error("reserved status bits changed");

  trig_alert_a: assert property (
    (r.ast == PHS_A_IDLE && any_trig) |=> !r.alert_n ##1 !r.alert_n)
    else $error("source fired without alert");

  ro_write_a: assert property (
    (rbus.wr && sel[0] && trig_s == 8'h00 && !rbus.rd) |=> r.st[6:0] == $past(r.st[6:0]))
    else $error("write changed read-only status bits");

  pulse_done_c: cover property (
    r.ast == PHS_A_PULSE ##1 r.ast == PHS_A_IDLE);

  hold_clear_c: cover property (
    r.ast == PHS_A_HOLD && clr_hit);

  fail_set_c: cover property (
    fail_set);

  exit_set_c: cover property (
    exit_set ##1 r.st[B_EXIT]);
endmodule : phs_alert_top

/* logic/phs_i2c_slv.sv */
// two-wire serial slave giving byte access to the status register pair
`timescale 1ns/1ps
module phs_i2c_slv
  import phs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = PHS_DEV_ADDR
)(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic [7:0] rdata,
  output logic            sda_out,
  output logic            sda_oe,
  output phs_rbus_s       rbus,
  output logic [7:0]      ptr
);
  typedef struct packed {
    logic [1:0] scl_q;
    logic [1:0] sda_q;
    logic       scl_d;
    logic       sda_d;
    phs_i2c_e   st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic [7:0] ptr;
    logic       oe;
    phs_rbus_s  bus;
  } phs_slv_st_s;

  localparam phs_slv_st_s RST_ST = '{scl_q: 2'h3, sda_q: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                                     st: PHS_I_IDLE, default: '0};
  localparam logic [3:0] BITS = 4'h8;

  phs_slv_st_s r;
  phs_slv_st_s n;
  logic        scl;
  logic        sda;
  logic        rise;
  logic        fall;

  // only stage two of each synchroniser is looked at
  assign scl  = r.scl_q[1];
  assign sda  = r.sda_q[1];
  assign rise = scl & ~r.scl_d;
  assign fall = ~scl & r.scl_d;

  always_comb begin
    n = r;
    n.scl_q = {r.scl_q[0], scl_pin};
    n.sda_q = {r.sda_q[0], sda_pin};
    n.scl_d = scl;
    n.sda_d = sda;
    n.bus.wr = 1'b0;
    n.bus.rd = 1'b0;
    if (scl && r.scl_d && r.sda_d && !sda) begin
      n.st = PHS_I_ADDR;
      n.cnt = '0;
      n.oe = 1'b0;
    end else if (scl && r.scl_d && !r.sda_d && sda) begin
      n.st = PHS_I_IDLE;
      n.oe = 1'b0;
    end else begin
      case (r.st)
        PHS_I_ADDR, PHS_I_PTR, PHS_I_WDAT: begin
          if (rise && r.cnt != BITS) begin
            n.sh = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == BITS) begin
            n.cnt = '0;
            n.oe = 1'b1;
            if (r.st == PHS_I_ADDR) begin
              n.rw = r.sh[0];
              n.st = PHS_I_AACK;
              if (r.sh[7:1] != DEV_ADDR) begin
                n.oe = 1'b0;
                n.st = PHS_I_IDLE;
              end
            end else if (r.st == PHS_I_PTR) begin
              n.ptr = r.sh;
              n.st = PHS_I_PACK;
            end else begin
              n.bus.wr = 1'b1;
              n.bus.addr = r.ptr;
              n.bus.wdata = r.sh;
              n.st = PHS_I_WACK;
            end
          end
        end
        PHS_I_AACK, PHS_I_RACK: begin
          if (r.st == PHS_I_RACK && rise) begin
            // master nack ends the read; an ack moves to the next byte
            if (sda) begin
              n.st = PHS_I_IDLE;
            end else begin
              n.ptr = r.ptr + 8'h01;
            end
          end else if (fall && (r.rw || r.st == PHS_I_RACK)) begin
            n.bus.rd = 1'b1;
            n.bus.addr = r.ptr;
            n.sh = rdata;
            n.oe = ~rdata[7];
            n.cnt = 4'h1;
            n.st = PHS_I_RDAT;
          end else if (fall) begin
            n.oe = 1'b0;
            n.st = PHS_I_PTR;
          end
        end
        PHS_I_PACK, PHS_I_WACK: begin
          if (fall) begin
            n.oe = 1'b0;
            n.st = PHS_I_WDAT;
            if (r.st == PHS_I_WACK) begin
              n.ptr = r.ptr + 8'h01;
            end
          end
        end
        PHS_I_RDAT: begin
          if (fall && r.cnt == BITS) begin
            n.oe = 1'b0;
            n.st = PHS_I_RACK;
          end else if (fall) begin
            n.oe = ~r.sh[6];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = r.cnt + 4'h1;
          end
        end
        PHS_I_IDLE: begin
          n.oe = 1'b0;
        end
        default: begin
          n.st = PHS_I_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= RST_ST;
    end else begin
      r <= n;
    end
  end

  // open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = r.oe;
  assign rbus    = r.bus;
  assign ptr     = r.ptr;
endmodule : phs_i2c_slv

/* logic/phs_pkg.sv */
// constants and types shared by the processor-hot status block
package phs_pkg;
  localparam int CLK_NS = 4;
  localparam int W0_NS  = 100000;
  localparam int W1_NS  = 1000000;
  localparam int W2_NS  = 10000000;
  localparam int W3_NS  = 5000000;
  localparam int W0_CYC = (W0_NS + CLK_NS - 1) / CLK_NS;
  localparam int W1_CYC = (W1_NS + CLK_NS - 1) / CLK_NS;
  localparam int W2_CYC = (W2_NS + CLK_NS - 1) / CLK_NS;
  localparam int W3_CYC = (W3_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W  = 22;
  localparam int FAIL_LIMIT = 7;

  localparam logic [7:0]  REG_LO     = 8'h22;
  localparam logic [7:0]  REG_HI     = 8'h23;
  localparam logic [15:0] STAT_RST   = 16'hA800;
  localparam logic [15:0] WR_MASK    = 16'h7B80;
  localparam logic [7:0]  LO_RO_MASK = 8'h7F;
  localparam int B_RSV_HI = 15;
  localparam int B_EXT    = 14;
  localparam int B_WID    = 12;
  localparam int B_CLR    = 11;
  localparam int B_RSV_LO = 10;
  localparam int B_FAIL   = 9;
  localparam int B_EXIT   = 8;
  localparam logic [6:0] PHS_DEV_ADDR = 7'h09;

  typedef enum logic [1:0] {PHS_A_IDLE, PHS_A_PULSE, PHS_A_HOLD} phs_alert_e;
  typedef enum logic [3:0] {
    PHS_I_IDLE, PHS_I_ADDR, PHS_I_AACK, PHS_I_PTR, PHS_I_PACK,
    PHS_I_WDAT, PHS_I_WACK, PHS_I_RDAT, PHS_I_RACK
  } phs_i2c_e;

  typedef struct packed {
    logic input_volt_reg_trig;
    logic comp_trig;
    logic critical_current_trig;
    logic nominal_current_trig;
    logic discharge_current_trig;
    logic system_voltage_trig;
    logic battery_removal_trig;
    logic adapter_removal_trig;
  } phs_trig_s;

  typedef struct packed {
    logic req;
    logic load_fail;
    logic load_ok;
    logic fault;
  } phs_assist_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } phs_rbus_s;
endpackage : phs_pkg
